// file: design/dkc_regs.vh
/*
 * Register offsets, field positions, reset values and counts for the
 * dark offset calibration engine.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef DKC_REGS_VH
`define DKC_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DKC_ADDR_CAL_REQ   8'h00
`define DKC_ADDR_CORR_MODE 8'h04
`define DKC_ADDR_ACQ_CTRL  8'h08
`define DKC_ADDR_FR_PERIOD 8'h0C
`define DKC_ADDR_WIN_START 8'h10
`define DKC_ADDR_WIN_WIDTH 8'h14
`define DKC_ADDR_STATUS    8'h18
`define DKC_ADDR_MAX_AVG   8'h1C

// ----------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------
`define DKC_GEN_MSB        2
`define DKC_GEN_DARK       3'h1
`define DKC_MODE_OFF       2'h0
`define DKC_MODE_DARK_BIT  0
`define DKC_MODE_PHOTO_BIT 1
`define DKC_ACQ_SINGLE_BIT 0
`define DKC_ACQ_FREE_BIT   1

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define DKC_FR_PERIOD_RST  16'h1000
`define DKC_CAL_LINES      7'h40
`define DKC_AVG_SHIFT      6

`endif

// file: design/dkc_accum.v
/*
 * Per-pixel accumulator array for the dark calibration lines.
 * Assumes one pixel per cycle at most and an index below NPIX.
 */
`timescale 1ns/10ps
`include "dkc_regs.vh"

module dkc_accum #(
    parameter NPIX  = 4096,
    parameter IW    = 12,
    parameter PIX_W = 12
) (
    input  wire             clock_i,  // system clock
    input  wire             acc_en_i, // add pixel this cycle
    input  wire             first_i,  // first line: load instead of add
    input  wire [IW-1:0]    wr_idx_i, // pixel being accumulated
    input  wire [PIX_W-1:0] data_i,   // pixel gray value
    input  wire [IW-1:0]    rd_idx_i, // pixel to read back
    output reg  [PIX_W-1:0] avg_o     // average, one cycle after rd_idx_i
);

    localparam AW = PIX_W + `DKC_AVG_SHIFT;

    reg [AW-1:0] acc_mem [0:NPIX-1];

    // ------------------------------------------------------------------
    // accumulate and read
    // ------------------------------------------------------------------
    // loading on the first line avoids a separate clearing pass
    always @(posedge clock_i)
    begin
        if (acc_en_i)
        begin
            if (first_i)
                acc_mem[wr_idx_i] <= {{`DKC_AVG_SHIFT{1'b0}}, data_i};
            else
                acc_mem[wr_idx_i] <= acc_mem[wr_idx_i] + {{`DKC_AVG_SHIFT{1'b0}}, data_i};
        end
        avg_o <= acc_mem[rd_idx_i][AW-1:`DKC_AVG_SHIFT]; // divide by 64
    end

endmodule // dkc_accum

// file: design/dkc_store.v
/*
 * Dark offset value store, two banks (single-line and other modes).
 * Mirrors the active user file, so pixels left unwritten keep old values.
 */
`timescale 1ns/10ps

module dkc_store #(
    parameter NPIX  = 4096,
    parameter IW    = 12,
    parameter PIX_W = 12
) (
    input  wire             clock_i, // system clock
    input  wire             we_i,    // write enable
    input  wire [IW:0]      waddr_i, // bank bit on top, then pixel
    input  wire [PIX_W-1:0] wdata_i, // offset value
    input  wire [IW:0]      raddr_i, // read address
    output reg  [PIX_W-1:0] rdata_o  // read data, one cycle later
);

    reg [PIX_W-1:0] off_mem [0:2*NPIX-1];

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // a pixel is undefined until the first calibration of its bank whose window covers it
    always @(posedge clock_i)
    begin
        if (we_i)
            off_mem[waddr_i] <= wdata_i;
        rdata_o <= off_mem[raddr_i];
    end

endmodule // dkc_store

// file: design/dkc_top.v
/*
 * Dark offset calibration engine: collects dark lines, averages them,
 * derives per-pixel offsets, saves them to non-volatile memory and
 * activates the user file.
 * Assumes inputs synchronous to clock_i and a non-volatile memory that
 * takes one word per request/ack handshake.
 */
`timescale 1ns/10ps
`include "dkc_regs.vh"

module dkc_top #(
    parameter NPIX  = 4096,
    parameter IW    = 12,
    parameter PIX_W = 12
) (
    input  wire             clock_i,                 // system clock, 200 MHz
    input  wire             reset_i,                 // synchronous reset, high
    input  wire [7:0]       reg_addr_i,              // register byte address
    input  wire [31:0]      reg_wdata_i,             // register write data
    input  wire             reg_wr_i,                // write strobe
    input  wire             reg_rd_i,                // read strobe
    output reg  [31:0]      reg_rdata_o,             // read data, cycle after strobe
    output reg              cmd_ack_o,               // command acknowledge pulse
    input  wire             external_line_trigger_i, // host line trigger
    output reg              line_trigger_o,          // line trigger to sensor
    input  wire             sens_lval_i,             // sensor line valid
    input  wire             sens_dval_i,             // sensor data valid
    input  wire [PIX_W-1:0] sens_data_i,             // sensor pixel data
    output reg              lval_o,                  // line valid out
    output reg              dval_o,                  // data valid out
    output reg  [PIX_W-1:0] data_o,                  // pixel data out
    output reg              nv_req_o,                // nv write request
    output reg  [IW:0]      nv_addr_o,               // nv word address
    output reg  [PIX_W-1:0] nv_data_o,               // nv write data
    input  wire             nv_ack_i,                // nv word accepted
    output reg              dark_corr_en_o,          // apply dark correction
    output reg              photo_corr_en_o,         // apply photo correction
    output reg              user_file_active_o,      // user file is active
    output wire             busy_o                   // calibration in progress
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_COLL  = 3'h1;
    localparam [2:0] ST_MAX   = 3'h2;
    localparam [2:0] ST_OFF   = 3'h3;
    localparam [2:0] ST_STORE = 3'h4;
    localparam [2:0] ST_ACT   = 3'h5;

    localparam [IW:0]   NPIX_L = NPIX[IW:0];
    // last word of the two-bank file, 2*NPIX-1, built at its own width
    localparam [IW+1:0] NV_LAST = {NPIX_L - 1'b1, 1'b1};

    reg [2:0]       state_reg;
    reg [1:0]       mode_reg;
    reg [1:0]       acq_reg;
    reg [15:0]      period_reg;
    reg [IW-1:0]    win_start_reg;
    reg [IW:0]      win_width_reg;
    reg             bank_reg;
    reg [15:0]      fr_cnt_reg;
    reg             lv_q_reg;
    reg             armed_reg;
    reg [IW-1:0]    pix_idx_reg;
    reg [6:0]       line_cnt_reg;
    reg [IW:0]      scan_idx_reg;
    reg             scan_v_reg;
    reg [IW-1:0]    scan_q_reg;
    reg [PIX_W-1:0] max_reg;
    reg [IW+1:0]    nv_idx_reg;
    reg [1:0]       nv_ph_reg;

    wire             cmd_ok;
    wire             start;
    wire             lv_rise;
    wire             lv_fall;
    wire [IW-1:0]    pix_cur;
    wire             acc_en;
    wire [PIX_W-1:0] avg;
    wire [PIX_W-1:0] st_rdata;
    wire             scanning;
    wire             scan_more;
    wire             scan_hit;
    wire [IW+1:0]    win_end;

    // ------------------------------------------------------------------
    // command gating
    // ------------------------------------------------------------------
    // busy indication
    assign busy_o = (state_reg != ST_IDLE);
    assign cmd_ok = ~busy_o;
    assign start  = reg_wr_i && cmd_ok && (reg_addr_i == `DKC_ADDR_CAL_REQ)
                    && (reg_wdata_i[`DKC_GEN_MSB:0] == `DKC_GEN_DARK);

    // register writes; other generate codes belong to other engines
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            mode_reg      <= `DKC_MODE_OFF;
            acq_reg       <= 2'h0;
            period_reg    <= `DKC_FR_PERIOD_RST;
            win_start_reg <= {IW{1'b0}};
            win_width_reg <= NPIX_L;
        end
        else if (reg_wr_i && cmd_ok)
        begin
            case (reg_addr_i)
                `DKC_ADDR_CORR_MODE: mode_reg      <= reg_wdata_i[1:0];
                `DKC_ADDR_ACQ_CTRL:  acq_reg       <= reg_wdata_i[1:0];
                `DKC_ADDR_FR_PERIOD: period_reg    <= reg_wdata_i[15:0];
                `DKC_ADDR_WIN_START: win_start_reg <= reg_wdata_i[IW-1:0];
                `DKC_ADDR_WIN_WIDTH: win_width_reg <= reg_wdata_i[IW:0];
                default:             mode_reg      <= mode_reg;
            endcase
        end
    end

    // register reads; unmapped and refused reads return zero
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= 32'h0;
            cmd_ack_o   <= 1'b0;
        end
        else
        begin
            cmd_ack_o   <= (reg_wr_i | reg_rd_i) & cmd_ok;
            reg_rdata_o <= 32'h0;
            if (reg_rd_i && cmd_ok)
            begin
                case (reg_addr_i)
                    `DKC_ADDR_CORR_MODE: reg_rdata_o <= {30'h0, mode_reg};
                    `DKC_ADDR_ACQ_CTRL:  reg_rdata_o <= {30'h0, acq_reg};
                    `DKC_ADDR_FR_PERIOD: reg_rdata_o <= {16'h0, period_reg};
                    `DKC_ADDR_WIN_START: reg_rdata_o[IW-1:0] <= win_start_reg;
                    `DKC_ADDR_WIN_WIDTH: reg_rdata_o[IW:0] <= win_width_reg;
                    `DKC_ADDR_STATUS:    reg_rdata_o <= {27'h0, user_file_active_o, bank_reg, state_reg};
                    `DKC_ADDR_MAX_AVG:   reg_rdata_o[PIX_W-1:0] <= max_reg;
                    default:             reg_rdata_o <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // line timing and video pass-through
    // ------------------------------------------------------------------
    // free-run internal line timing or external trigger pass-through
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            fr_cnt_reg     <= 16'h0;
            line_trigger_o <= 1'b0;
        end
        else if (acq_reg[`DKC_ACQ_FREE_BIT])
        begin
            line_trigger_o <= (fr_cnt_reg == 16'h0);
            fr_cnt_reg     <= (fr_cnt_reg >= period_reg - 16'h1) ? 16'h0 : fr_cnt_reg + 16'h1;
        end
        else
        begin
            fr_cnt_reg     <= 16'h0;
            line_trigger_o <= external_line_trigger_i;
        end
    end

    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            lval_o <= 1'b0;
            dval_o <= 1'b0;
            data_o <= {PIX_W{1'b0}};
        end
        else
        begin
            lval_o <= sens_lval_i;
            dval_o <= sens_dval_i;
            data_o <= sens_data_i;
        end
    end

    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            dark_corr_en_o  <= 1'b0;
            photo_corr_en_o <= 1'b0;
        end
        else
        begin
            dark_corr_en_o  <= mode_reg[`DKC_MODE_DARK_BIT];
            photo_corr_en_o <= mode_reg[`DKC_MODE_PHOTO_BIT];
        end
    end

    // ------------------------------------------------------------------
    // line collection
    // ------------------------------------------------------------------
    assign lv_rise = sens_lval_i & ~lv_q_reg;
    assign lv_fall = ~sens_lval_i & lv_q_reg;
    assign pix_cur = lv_rise ? {IW{1'b0}} : pix_idx_reg;
    // only whole lines starting after the request are summed
    assign acc_en  = (state_reg == ST_COLL) && (armed_reg | lv_rise)
                     && sens_lval_i && sens_dval_i;

    // ------------------------------------------------------------------
    // averaging scans
    // ------------------------------------------------------------------
    assign scanning  = (state_reg == ST_MAX) || (state_reg == ST_OFF);
    assign scan_more = (scan_idx_reg < NPIX_L);
    assign win_end   = {2'b00, win_start_reg} + {1'b0, win_width_reg};
    assign scan_hit  = scan_v_reg && (scan_q_reg >= win_start_reg)
                       && ({2'b00, scan_q_reg} < win_end);

    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_reg          <= ST_IDLE;
            bank_reg           <= 1'b0;
            lv_q_reg           <= 1'b0;
            armed_reg          <= 1'b0;
            pix_idx_reg        <= {IW{1'b0}};
            line_cnt_reg       <= 7'h0;
            scan_idx_reg       <= {(IW+1){1'b0}};
            scan_v_reg         <= 1'b0;
            scan_q_reg         <= {IW{1'b0}};
            max_reg            <= {PIX_W{1'b0}};
            nv_idx_reg         <= {(IW+2){1'b0}};
            nv_ph_reg          <= 2'h0;
            nv_req_o           <= 1'b0;
            nv_addr_o          <= {(IW+1){1'b0}};
            nv_data_o          <= {PIX_W{1'b0}};
            user_file_active_o <= 1'b0;
        end
        else
        begin
            lv_q_reg   <= sens_lval_i;
            scan_v_reg <= scanning && scan_more;
            scan_q_reg <= scan_idx_reg[IW-1:0];
            if (scanning && scan_more)
                scan_idx_reg <= scan_idx_reg + {{IW{1'b0}}, 1'b1};
            if (sens_dval_i && sens_lval_i)
                pix_idx_reg <= pix_cur + {{(IW-1){1'b0}}, 1'b1};
            else if (lv_rise)
                pix_idx_reg <= {IW{1'b0}};
            case (state_reg)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        bank_reg     <= acq_reg[`DKC_ACQ_SINGLE_BIT];
                        armed_reg    <= 1'b0;
                        line_cnt_reg <= 7'h0;
                        max_reg      <= {PIX_W{1'b0}};
                        state_reg    <= ST_COLL;
                    end
                end
                ST_COLL:
                begin
                    if (lv_rise)
                        armed_reg <= 1'b1;
                    if (lv_fall && armed_reg)
                    begin
                        line_cnt_reg <= line_cnt_reg + 7'h1;
                        if (line_cnt_reg == `DKC_CAL_LINES - 7'h1)
                        begin
                            scan_idx_reg <= {(IW+1){1'b0}};
                            state_reg    <= ST_MAX;
                        end
                    end
                end
                ST_MAX:
                begin
                    if (scan_hit && (avg > max_reg))
                        max_reg <= avg;
                    if (!scan_more && !scan_v_reg)
                    begin
                        scan_idx_reg <= {(IW+1){1'b0}};
                        state_reg    <= ST_OFF;
                    end
                end
                ST_OFF:
                begin
                    if (!scan_more && !scan_v_reg)
                    begin
                        nv_idx_reg <= {(IW+2){1'b0}};
                        nv_ph_reg  <= 2'h0;
                        state_reg  <= ST_STORE;
                    end
                end
                ST_STORE:
                begin
                    // write whole file to nv memory
                    case (nv_ph_reg)
                        2'h0: nv_ph_reg <= 2'h1;
                        2'h1:
                        begin
                            nv_req_o  <= 1'b1;
                            nv_addr_o <= nv_idx_reg[IW:0];
                            nv_data_o <= st_rdata;
                            nv_ph_reg <= 2'h2;
                        end
                        2'h2:
                        begin
                            if (nv_ack_i)
                            begin
                                nv_req_o   <= 1'b0;
                                nv_idx_reg <= nv_idx_reg + {{(IW+1){1'b0}}, 1'b1};
                                nv_ph_reg  <= 2'h0;
                                if (nv_idx_reg == NV_LAST)
                                    state_reg <= ST_ACT;
                            end
                        end
                        default: nv_ph_reg <= 2'h0;
                    endcase
                end
                ST_ACT:
                begin
                    user_file_active_o <= 1'b1;
                    state_reg          <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // per-pixel average over 64 lines
    dkc_accum #(
        .NPIX  (NPIX),
        .IW    (IW),
        .PIX_W (PIX_W)
    ) u_accum (
        .clock_i  (clock_i),
        .acc_en_i (acc_en),
        .first_i  (line_cnt_reg == 7'h0),
        .wr_idx_i (pix_cur),
        .data_i   (sens_data_i),
        .rd_idx_i (scan_idx_reg[IW-1:0]),
        .avg_o    (avg)
    );

    dkc_store #(
        .NPIX  (NPIX),
        .IW    (IW),
        .PIX_W (PIX_W)
    ) u_store (
        .clock_i (clock_i),
        .we_i    ((state_reg == ST_OFF) && scan_hit),
        .waddr_i ({bank_reg, scan_q_reg}),
        .wdata_i (max_reg - avg),
        .raddr_i (nv_idx_reg[IW:0]),
        .rdata_o (st_rdata)
    );

endmodule // dkc_top

// file: sim/dkc_chk.sv
/* assertion checker for dkc_top, bound from the bench top file
   sees only the top module's ports */
`timescale 1ns/10ps
`include "dkc_regs.vh"
module dkc_chk #(parameter NPIX = 16, IW = 4, PIX_W = 12) (
    input wire             clock_i,            // clock
    input wire             reset_i,            // reset
    input wire [7:0]       reg_addr_i,         // address
    input wire [31:0]      reg_wdata_i,        // write data
    input wire             reg_wr_i,           // write strobe
    input wire             reg_rd_i,           // read strobe
    input wire             cmd_ack_o,          // acknowledge
    input wire             sens_lval_i,        // sensor lval
    input wire             lval_o,             // lval out
    input wire             nv_req_o,           // nv request
    input wire [IW:0]      nv_addr_o,          // nv address
    input wire [PIX_W-1:0] nv_data_o,          // nv data
    input wire             nv_ack_i,           // nv accept
    input wire             user_file_active_o, // file active
    input wire             busy_o              // calibrating
);
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // a strobe counts only while idle; busy refuses the command link
    wire take = (reg_wr_i | reg_rd_i) & ~busy_o;
    wire start = take & reg_wr_i & (reg_addr_i == `DKC_ADDR_CAL_REQ) & (reg_wdata_i[`DKC_GEN_MSB:0] == `DKC_GEN_DARK);
    a_ack_cause: assert property (cmd_ack_o |-> $past(take)) else $error("ack without taken strobe");
    a_ack_given: assert property (take |=> cmd_ack_o) else $error("taken strobe not acknowledged");
    a_cal_start: assert property (start |=> busy_o) else $error("calibration did not start");
    a_video_copy: assert property (1'b1 |=> lval_o == $past(sens_lval_i)) else $error("lval not passed on");
    a_nv_hold: assert property (nv_req_o && !nv_ack_i |=> nv_req_o && $stable({nv_addr_o, nv_data_o}))
        else $error("nv word changed before accept");
    a_nv_drop: assert property (nv_req_o && nv_ack_i |=> !nv_req_o) else $error("nv request kept");
    a_nv_in_busy: assert property (nv_req_o |-> busy_o) else $error("nv write outside calibration");
    a_active_kept: assert property (user_file_active_o |=> user_file_active_o) else $error("file dropped");
    a_activate: assert property ($fell(busy_o) |-> ##[0:2] user_file_active_o) else $error("not activated");
endmodule // dkc_chk

// file: sim/dkc_nvm_model.sv
/* non-volatile memory model: keeps each word, accepts after a random wait
   assumes the request is held until accepted */
`timescale 1ns/10ps
module dkc_nvm_model #(parameter NPIX = 16, IW = 4, PIX_W = 12) (
    input  wire             clock_i,         // clock
    input  wire             req_i,           // write request
    input  wire [IW:0]      addr_i,          // word address
    input  wire [PIX_W-1:0] data_i,          // word data
    output reg              ack_o = 1'b0,    // accept pulse
    output reg  [31:0]      count_o = 32'h0  // words kept
);
    reg [PIX_W-1:0] mem [0:2*NPIX-1];
    reg [2:0]       wait_reg = 3'h0;
    reg [7:0]       lfsr_reg = 8'hB5;
    // varying wait gives prompt and slow accepts; never two per word
    always @(posedge clock_i)
    begin
        ack_o    <= 1'b0;
        lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        if (req_i && !ack_o && wait_reg != 3'h0)
            wait_reg <= wait_reg - 3'h1;
        else if (req_i && !ack_o)
        begin
            ack_o       <= 1'b1;
            mem[addr_i] <= data_i;
            count_o     <= count_o + 32'h1;
            wait_reg    <= lfsr_reg[2:0];
        end
    end
endmodule // dkc_nvm_model

// file: sim/tb_dkc_top.sv
/* self-checking bench for dkc_top with a memory model
   assumes a 200 MHz clock and the pixel count cut to 16 */
`timescale 1ns/10ps
`include "dkc_regs.vh"
module tb_dkc_top;
    localparam NPIX = 16, IW = 4, PIX_W = 12;
    reg              clock_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    reg              external_line_trigger_i = 1'b0, sens_lval_i = 1'b0, sens_dval_i = 1'b0;
    reg  [7:0]       reg_addr_i = 8'h00;
    reg  [31:0]      reg_wdata_i = 32'h0, rv = 32'h96AC01C8, q;
    reg  [PIX_W-1:0] sens_data_i = 12'h000, pix, mx, prev [0:1][0:NPIX-1];
    reg  [19:0]      sum [0:NPIX-1];
    reg  [1:0]       known = 2'b00;
    wire [31:0]      reg_rdata_o, nv_count;
    wire [PIX_W-1:0] data_o, nv_data_o;
    wire [IW:0]      nv_addr_o;
    wire             cmd_ack_o, line_trigger_o, lval_o, dval_o, nv_req_o, nv_ack_i, busy_o;
    wire             dark_corr_en_o, photo_corr_en_o, user_file_active_o;
    integer          err_total = 0, total_checks = 0, p, i, n, c0;
    always #2.5 clock_i = ~clock_i;
    dkc_top #(.NPIX(NPIX), .IW(IW), .PIX_W(PIX_W)) i_dkc_top (.*);
    dkc_nvm_model #(.NPIX(NPIX), .IW(IW), .PIX_W(PIX_W)) i_dkc_nvm_model (.clock_i(clock_i), .req_i(nv_req_o),
        .addr_i(nv_addr_o), .data_i(nv_data_o), .ack_o(nv_ack_i), .count_o(nv_count));
    // xorshift source, fixed start so every run repeats
    function [31:0] xs(input [31:0] s);
    begin
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // one bus cycle; read data are taken in the cycle after the strobe only
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= w;
        reg_rd_i    <= !w;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b0;
        #1 q = reg_rdata_o;
    end
    endtask
    // one dark calibration: mode and window set first, then 64 lines
    task calib(input single, input free, input [31:0] ws, input [31:0] ww);
    begin
        bus(1'b1, `DKC_ADDR_ACQ_CTRL, {30'h0, free, single});
        bus(1'b1, `DKC_ADDR_WIN_START, ws);
        bus(1'b1, `DKC_ADDR_WIN_WIDTH, ww);
        for (p = 0; p < NPIX; p = p + 1) sum[p] = 20'h0;
        c0 = nv_count;
        bus(1'b1, `DKC_ADDR_CAL_REQ, {29'h0, `DKC_GEN_DARK});
        chk(busy_o, 1);
        for (i = 0; i < 64; i = i + 1)
        begin
            // commands in mid-collection must be ignored
            if (i == 8)
            begin
                bus(1'b1, `DKC_ADDR_CORR_MODE, 32'h0);
                bus(1'b0, `DKC_ADDR_CORR_MODE, 32'h0);
                chk(q, 0);
                chk({photo_corr_en_o, dark_corr_en_o}, 3);
            end
            if (!free) @(posedge clock_i) external_line_trigger_i <= 1'b1;
            if (!free) @(posedge clock_i) external_line_trigger_i <= 1'b0;
            n = 0;
            while (line_trigger_o !== 1'b1 && n < 200) @(negedge clock_i) n = n + 1;
            chk(line_trigger_o, 1);
            for (p = 0; p < NPIX; p = p + 1)
            begin
                @(posedge clock_i);
                rv = xs(rv);
                pix = {2'h0, rv[9:0]};
                sum[p] = sum[p] + pix;
                {sens_lval_i, sens_dval_i, sens_data_i} <= {2'b11, pix};
            end
            @(posedge clock_i);
            {sens_lval_i, sens_dval_i, sens_data_i} <= {2'b00, ~pix};
            @(negedge clock_i) chk({lval_o, dval_o, data_o}, {2'b11, pix});
            repeat (2) @(posedge clock_i);
        end
        n = 0;
        while (busy_o !== 1'b0 && n < 3000) @(negedge clock_i) n = n + 1;
        chk(busy_o, 0);
        chk(user_file_active_o, 1);
        chk(nv_count - c0, 2 * NPIX);
        mx = 12'h000;
        for (p = ws; p < ws + ww; p = p + 1) if (sum[p][17:6] > mx) mx = sum[p][17:6];
        for (p = 0; p < NPIX; p = p + 1)
        begin
            if (p >= ws && p < ws + ww) prev[single][p] = mx - sum[p][17:6];
            if (known[single] || (p >= ws && p < ws + ww))
                chk(i_dkc_nvm_model.mem[{single, p[IW-1:0]}], prev[single][p]);
            if (known[!single]) chk(i_dkc_nvm_model.mem[{!single, p[IW-1:0]}], prev[!single][p]);
        end
        known[single] = 1'b1;
        $display("calibration test done, bank %0d", single);
    end
    endtask
    task conclude;
    begin
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // main sequence: register port first, then three calibrations
    initial
    begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        bus(1'b0, `DKC_ADDR_FR_PERIOD, 32'h0);
        chk(q, {16'h0, `DKC_FR_PERIOD_RST});
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 0);
        chk(user_file_active_o, 0);
        bus(1'b1, `DKC_ADDR_CAL_REQ, 32'h2);
        chk(busy_o, 0);
        for (i = 0; i < 4; i = i + 1)
        begin
            bus(1'b1, `DKC_ADDR_CORR_MODE, i);
            // enables follow the mode register one edge later
            @(posedge clock_i) #1 chk({photo_corr_en_o, dark_corr_en_o}, i);
        end
        $display("register test done");
        bus(1'b1, `DKC_ADDR_FR_PERIOD, 32'h28);
        calib(1'b0, 1'b0, 0, NPIX);
        calib(1'b1, 1'b1, 0, NPIX);
        calib(1'b0, 1'b1, 4, 8);
        conclude;
    end
    // watchdog: the whole run needs well under a fifth of this span
    initial
    begin
        #400000;
        err_total = err_total + 1;
        conclude;
    end
endmodule // tb_dkc_top
bind dkc_top dkc_chk #(.NPIX(NPIX), .IW(IW), .PIX_W(PIX_W)) i_dkc_chk (.*);
